// *** src/fcs_reg3.v ***
`timescale 1ns/100ps
`include "fcs_regs.vh"
module fcs_reg3 #(
  parameter BLK_SHIFT = 16,
  parameter BLK_BITS  = 6
) (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  // Serial link pins
  input  wire        sclk_i,
  input  wire        cs_n_i,
  input  wire        mosi_i,
  output reg         miso_o,
  output reg         miso_oe_o,
  // Pin configuration
  output reg         hold_enable_o,
  output reg         reset_enable_o,
  output reg  [1:0]  output_drive_level_o,
  // Protection query from array logic
  input  wire [23:0] chk_addr_i,
  output reg         chk_protected_o,
  output reg         protect_scheme_select_o
);
  localparam NBLK = 1 << BLK_BITS;

  reg [2:0]      sclk_s;
  reg [2:0]      cs_s;
  reg [1:0]      mosi_s;
  reg [7:0]      sr1;
  reg [7:0]      sr2;
  reg [7:0]      pin_drive_protect_config;
  reg [NBLK-1:0] locks;
  reg [7:0]      shift_in;
  reg [7:0]      shift_out;
  reg [2:0]      bit_cnt;
  reg [2:0]      byte_cnt;
  reg [7:0]      cmd;
  reg [7:0]      d1;
  reg [7:0]      d2;
  reg [23:0]     addr;
  reg            rd_active;

  // Synchronisers: stage 0 feeds only stage 1
  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire sclk_fall = ~sclk_s[1] & sclk_s[2];
  wire cs_rise   = cs_s[1] & ~cs_s[2];
  wire cs_fall   = ~cs_s[1] & cs_s[2];
  wire cs_act    = ~cs_s[1];
  wire [7:0] next_in = {shift_in[6:0], mosi_s[1]};
  wire byte_done = cs_act & sclk_rise & (bit_cnt == 3'h7);
  wire wr_latch = sr1[`FCS_SR1_WR_LATCH];
  // Field views of the third register and the quad enable
  wire       pin_role       = pin_drive_protect_config[`FCS_SR3_PINROLE];
  wire [1:0] drive_cfg      = pin_drive_protect_config[`FCS_SR3_DRIVE_HI:`FCS_SR3_DRIVE_LO];
  wire       scheme_sel     = pin_drive_protect_config[`FCS_SR3_SCHEME];
  wire       quad_io_enable = sr2[`FCS_SR2_QUAD_IO];

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sclk_s <= 3'h0;
      cs_s   <= 3'h7;
      mosi_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk_i};
      cs_s   <= {cs_s[1:0], cs_n_i};
      mosi_s <= {mosi_s[0], mosi_i};
    end
  end

  // Value returned by a status read command
  reg [7:0] rd_val;
  always @* begin
    case (cmd)
      `FCS_CMD_RDSR1: rd_val = sr1;
      `FCS_CMD_RDSR2: rd_val = sr2;
      `FCS_CMD_RDSR3: rd_val = pin_drive_protect_config;
      default:        rd_val = 8'h00;
    endcase
  end

  // Reserved lanes forced to zero, reserved drive code keeps old value
  function [7:0] sr3_merge;
    input [7:0] old;
    input [7:0] d;
    reg   [1:0] lvl;
    begin
      lvl = d[`FCS_SR3_DRIVE_HI:`FCS_SR3_DRIVE_LO];
      if (lvl == `FCS_DRIVE_RSVD) begin
        lvl = old[`FCS_SR3_DRIVE_HI:`FCS_SR3_DRIVE_LO];
      end
      sr3_merge = {d[`FCS_SR3_PINROLE], lvl, 2'h0, d[`FCS_SR3_SCHEME], 2'h0};
    end
  endfunction

  // Shift engine; frames commit on chip select release
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sr1       <= `FCS_SR1_RESET;
      sr2       <= `FCS_SR2_RESET;
      pin_drive_protect_config <= `FCS_SR3_RESET;
      locks     <= {NBLK{1'b1}};
      shift_in  <= 8'h00;
      shift_out <= 8'h00;
      bit_cnt   <= 3'h0;
      byte_cnt  <= 3'h0;
      cmd       <= 8'h00;
      d1        <= 8'h00;
      d2        <= 8'h00;
      addr      <= 24'h000000;
      rd_active <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt   <= 3'h0;
      byte_cnt  <= 3'h0;
      cmd       <= 8'h00;
      rd_active <= 1'b0;
    end else if (cs_rise) begin
      rd_active <= 1'b0;
      // Commit only whole frames; a partial byte is discarded
      if (bit_cnt == 3'h0 && byte_cnt != 3'h0) begin
        case (cmd)
          `FCS_CMD_WREN: sr1[`FCS_SR1_WR_LATCH] <= 1'b1;
          `FCS_CMD_WRDI: sr1[`FCS_SR1_WR_LATCH] <= 1'b0;
          `FCS_CMD_WRSR1: if (wr_latch && byte_cnt > 3'h1) begin
            sr1 <= d1 & `FCS_SR1_WMASK;
            if (byte_cnt > 3'h2) begin
              sr2 <= d2;
            end
          end
          `FCS_CMD_WRSR2: if (wr_latch && byte_cnt > 3'h1) begin
            sr2 <= d1;
            sr1[`FCS_SR1_WR_LATCH] <= 1'b0;
          end
          `FCS_CMD_WRSR3: if (wr_latch && byte_cnt > 3'h1) begin
            pin_drive_protect_config <= sr3_merge(pin_drive_protect_config, d1);
            sr1[`FCS_SR1_WR_LATCH] <= 1'b0;
          end
          `FCS_CMD_WRSRA: if (wr_latch && byte_cnt > 3'h2) begin
            sr1[`FCS_SR1_WR_LATCH] <= 1'b0;
            case (d1)
              `FCS_SEL_SR1: sr1 <= d2 & `FCS_SR1_WMASK;
              `FCS_SEL_SR2: sr2 <= d2;
              `FCS_SEL_SR3: pin_drive_protect_config <= sr3_merge(pin_drive_protect_config, d2);
              default: ;
            endcase
          end
          `FCS_CMD_LOCK, `FCS_CMD_UNLOCK: begin
            sr1[`FCS_SR1_WR_LATCH] <= 1'b0;
            if (wr_latch && byte_cnt > 3'h3 && scheme_sel) begin
              locks[addr[BLK_SHIFT+BLK_BITS-1:BLK_SHIFT]] <= (cmd == `FCS_CMD_LOCK);
            end
          end
          default: ;
        endcase
      end
    end else if (cs_act) begin
      if (sclk_rise) begin
        shift_in <= next_in;
        bit_cnt  <= bit_cnt + 3'h1;
      end
      if (byte_done) begin
        if (byte_cnt != 3'h7) begin
          byte_cnt <= byte_cnt + 3'h1;
        end
        case (byte_cnt)
          3'h0: cmd <= next_in;
          3'h1: d1  <= next_in;
          3'h2: d2  <= next_in;
          default: ;
        endcase
        if (byte_cnt != 3'h0 && byte_cnt < 3'h4) begin
          addr <= {addr[15:0], next_in};
        end
        if (byte_cnt == 3'h0) begin
          rd_active <= (next_in == `FCS_CMD_RDSR1) || (next_in == `FCS_CMD_RDSR2) ||
                       (next_in == `FCS_CMD_RDSR3);
        end
      end
      // Reload each byte so the register streams repeatedly
      if (sclk_fall && bit_cnt == 3'h0) begin
        shift_out <= rd_val;
      end else if (sclk_fall) begin
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

  // Range decode of first register in blocks
  wire [BLK_BITS-1:0] blk = chk_addr_i[BLK_SHIFT+BLK_BITS-1:BLK_SHIFT];
  wire [2:0] rng_bits = sr1[`FCS_SR1_RANGE_HI:`FCS_SR1_RANGE_LO];
  wire [3:0] sh  = {1'b0, rng_bits} - 4'h1 + {3'h0, ~sr1[`FCS_SR1_GRAN]};
  wire [BLK_BITS+8:0] size = {{BLK_BITS+8{1'b0}}, 1'b1} << sh;
  wire [BLK_BITS+8:0] blkw = {9'h000, blk};
  wire in_rng = (rng_bits != 3'h0) && (sr1[`FCS_SR1_BOTTOM] ? (blkw < size)
                : (blkw + size >= NBLK));
  wire rng_prot = in_rng ^ sr1[`FCS_SR1_CMP];

  // Registered outputs
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      miso_o                  <= 1'b0;
      miso_oe_o               <= 1'b0;
      hold_enable_o           <= 1'b0;
      reset_enable_o          <= 1'b0;
      output_drive_level_o    <= 2'h0;
      chk_protected_o         <= 1'b1;
      protect_scheme_select_o <= 1'b0;
    end else begin
      miso_o    <= rd_active & shift_out[7];
      miso_oe_o <= rd_active & cs_act;
      // Quad mode turns the shared pin into a plain data line
      hold_enable_o  <= ~quad_io_enable & ~pin_role;
      reset_enable_o <= ~quad_io_enable & pin_role;
      // Drive code only meaningful while read data is driven
      output_drive_level_o <= (rd_active & cs_act) ? drive_cfg : 2'h0;
      protect_scheme_select_o <= scheme_sel;
      chk_protected_o <= scheme_sel ? locks[blk]
                                    : rng_prot;
    end
  end
endmodule // fcs_reg3

// *** common/fcs_regs.vh ***
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
// Commands
`define FCS_CMD_WREN      8'h06
`define FCS_CMD_WRDI      8'h04
`define FCS_CMD_WRSR1     8'h01
`define FCS_CMD_WRSR2     8'h31
`define FCS_CMD_WRSR3     8'h11
`define FCS_CMD_WRSRA     8'h71
`define FCS_CMD_RDSR1     8'h05
`define FCS_CMD_RDSR2     8'h35
`define FCS_CMD_RDSR3     8'h15
`define FCS_CMD_LOCK      8'h36
`define FCS_CMD_UNLOCK    8'h39
// Register selectors for the addressed write
`define FCS_SEL_SR1       8'h01
`define FCS_SEL_SR2       8'h02
`define FCS_SEL_SR3       8'h03
// Third register fields and reset
`define FCS_SR3_PINROLE   7
`define FCS_SR3_DRIVE_HI  6
`define FCS_SR3_DRIVE_LO  5
`define FCS_SR3_SCHEME    2
`define FCS_SR3_RESET     8'h20
`define FCS_DRIVE_RSVD    2'h0
// First register fields
`define FCS_SR1_WR_LATCH  1
`define FCS_SR1_RANGE_HI  4
`define FCS_SR1_RANGE_LO  2
`define FCS_SR1_BOTTOM    5
`define FCS_SR1_GRAN      6
`define FCS_SR1_CMP       7
`define FCS_SR1_RESET     8'h00
`define FCS_SR1_WMASK     8'hfc
// Second register fields
`define FCS_SR2_QUAD_IO   1
`define FCS_SR2_RESET     8'h00
`endif

// *** bench/fcs_reg3_chk.sv ***
`timescale 1ns/100ps
// Port watch for the pin-role, drive and scheme outputs
module fcs_reg3_chk (
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  // Watched ports
  input wire logic       cs_n_i,
  input wire logic       miso_oe_o,
  input wire logic       hold_enable_o,
  input wire logic       reset_enable_o,
  input wire logic [1:0] output_drive_level_o,
  input wire logic       protect_scheme_select_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Commits land only after the frame has closed
  a_role_excl: assert property (!(hold_enable_o && reset_enable_o))
    else $error("hold and reset roles both on");
  a_hold_idle: assert property ($changed(hold_enable_o) |-> cs_n_i)
    else $error("hold role moved inside a frame");
  a_reset_idle: assert property ($changed(reset_enable_o) |-> cs_n_i)
    else $error("reset role moved inside a frame");
  a_scheme_idle: assert property ($changed(protect_scheme_select_o) |-> cs_n_i && $past(cs_n_i))
    else $error("scheme moved inside a frame");
  // Drive code only while returning data, never the reserved code
  a_drive_rsvd: assert property (miso_oe_o && $past(miso_oe_o) |-> output_drive_level_o != 2'h0)
    else $error("reserved drive code while reading");
  a_drive_idle: assert property (!miso_oe_o && !$past(miso_oe_o) |-> output_drive_level_o == 2'h0)
    else $error("drive code outside a read");
  a_drive_steady: assert property (miso_oe_o && $past(miso_oe_o) |-> $stable(output_drive_level_o))
    else $error("drive code changed during a read");
  a_oe_in_frame: assert property ($rose(miso_oe_o) |-> !cs_n_i)
    else $error("output enabled without select");
  a_oe_release: assert property (cs_n_i [*4] |=> !miso_oe_o)
    else $error("output still enabled after deselect");
endmodule // fcs_reg3_chk

bind fcs_reg3 fcs_reg3_chk chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
  .miso_oe_o(miso_oe_o), .hold_enable_o(hold_enable_o), .reset_enable_o(reset_enable_o),
  .output_drive_level_o(output_drive_level_o),
  .protect_scheme_select_o(protect_scheme_select_o));

// *** bench/fcs_host.sv ***
`timescale 1ns/100ps
// Host end of the link, mode 0; clock parked low between frames
module fcs_host (
  // Link pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Select, then leave room for the device's synchronisers
  task automatic begin_f();
    cs_n_o = 1'b0;
    #100;
  endtask
  // One byte MSB first, answer taken at each rise
  task automatic xb(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = b[i];
      #80 sclk_o = 1'b1;
      r[i] = miso_i;
      #80 sclk_o = 1'b0;
    end
  endtask
  // Data line flips on release so a stale bit never looks valid
  task automatic end_f();
    #100 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #200;
  endtask
  // Whole frame of n bytes, command first
  task automatic fr(input int n, input logic [31:0] d);
    logic [7:0] r;
    begin_f();
    for (int k = n - 1; k >= 0; k--) xb(d[8*k +: 8], r);
    end_f();
  endtask
  // Write enable always ahead of a write
  task automatic wr(input int n, input logic [31:0] d);
    fr(1, 32'h06);
    fr(n, d);
  endtask
endmodule // fcs_host

// *** bench/fcs_reg3_test.sv ***
`timescale 1ns/100ps
`include "fcs_regs.vh"
module fcs_reg3_test;
  logic        ref_clk_i, rst_n_i, sclk, cs_n, mosi, miso, miso_oe, hold, rst_en, scheme, prt;
  logic [1:0]  drive_lvl;
  logic [23:0] addr;
  logic [7:0]  r;
  int          n_fail = 0;
  int          comparisons = 0;
  // Far side and device; idle line shows inverse of the miso output
  fcs_host host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_oe ? miso : ~miso));
  fcs_reg3 dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .hold_enable_o(hold),
    .reset_enable_o(rst_en), .output_drive_level_o(drive_lvl), .chk_addr_i(addr),
    .chk_protected_o(prt), .protect_scheme_select_o(scheme));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Read register three, drive code looked at while data is out
  task automatic rd3(input logic [7:0] e, input logic [1:0] ed);
    host.begin_f();
    host.xb(`FCS_CMD_RDSR3, r);
    host.xb(8'h00, r);
    @(posedge ref_clk_i) #1;
    chk("drive", {6'h0, ed}, {6'h0, drive_lvl});
    chk("reg3", e, r);
    host.end_f();
  endtask
  task automatic pins(input logic [2:0] e);
    @(posedge ref_clk_i) #1;
    chk("hold reset scheme", {5'h0, e}, {5'h0, hold, rst_en, scheme});
  endtask
  task automatic prot(input logic [23:0] a, input logic e);
    @(posedge ref_clk_i) #1 addr = a;
    repeat (2) @(posedge ref_clk_i);
    #1 chk("protected", {7'h0, e}, {7'h0, prt});
  endtask
  task automatic t_reset();
    pins(3'b100);
    rd3(8'h20, 2'h1);
    prot(24'h3f0000, 1'b0);
  endtask
  task automatic t_write();
    host.wr(2, 32'h11ff);
    pins(3'b011);
    rd3(8'he4, 2'h3);
    prot(24'h050000, 1'b1);
  endtask
  // No latch set, then the reserved drive code, then a latch cleared again
  task automatic t_refuse();
    host.fr(2, 32'h1120);
    rd3(8'he4, 2'h3);
    host.wr(2, 32'h1104);
    rd3(8'h64, 2'h3);
    pins(3'b101);
    host.fr(1, 32'h06);
    host.fr(1, 32'h04);
    host.fr(2, 32'h1120);
    rd3(8'h64, 2'h3);
  endtask
  task automatic t_lock();
    host.wr(4, 32'h39050000);
    prot(24'h05ffff, 1'b0);
    prot(24'h060000, 1'b1);
    host.wr(4, 32'h36050000);
    prot(24'h050000, 1'b1);
    host.wr(4, 32'h39050000);
  endtask
  // Reset in mid-run puts the block 5 lock, the drive code and the scheme select back
  task automatic t_rst2();
    @(posedge ref_clk_i) #1 rst_n_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    rd3(8'h20, 2'h1);
    pins(3'b100);
    host.wr(2, 32'h1104);
    prot(24'h050000, 1'b1);
  endtask
  // Quad mode, addressed write, range decode, then an unlock refused
  task automatic t_quad();
    host.wr(3, 32'h010002);
    pins(3'b001);
    host.wr(2, 32'h3100);
    pins(3'b101);
    host.wr(3, 32'h710340);
    rd3(8'h40, 2'h2);
    prot(24'h050000, 1'b0);
    host.wr(2, 32'h0104);
    prot(24'h3f0000, 1'b1);
    prot(24'h3d0000, 1'b0);
    host.wr(2, 32'h01a4);
    prot(24'h010000, 1'b0);
    prot(24'h200000, 1'b1);
    host.wr(4, 32'h39050000);
    host.wr(2, 32'h1144);
    prot(24'h050000, 1'b1);
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    rst_n_i = 1'b0;
    addr = 24'h0;
    repeat (20) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_reset();
    t_write();
    t_refuse();
    t_lock();
    t_rst2();
    t_quad();
    end_of_test();
  end
  // Whole run is near 104 us; far past that means a hang
  initial begin
    #300000;
    n_fail++;
    end_of_test();
  end
endmodule // fcs_reg3_test
